// [design/mcr_pkg.sv]
// What this block does
// - bit 11 enables local analogue loopback
// - host keeps tx/rx modes equal in loopback; the host only flags a mismatch in status, it does not block it
// - bit 10 disables fixed compromise equalisers
// - bit 9 drives active-low relay output
// - bit 8 powers up, else powersave
// - general reset clears powerup bit
// - host resets, then powerup+reset for 20ms
// - leaving powersave, host holds reset 20ms
// - reset bit clears modes and status
// - bit 6 lets interrupt flag pull pin
// - bits 5-0 mask interrupt conditions
// - reset bit or command clears tx mode
// - tx mode field selects modem standard
// - host never writes reserved mode codes; the host refuses them on tx mode writes only, rx mode writes go out unchecked
// - level field sets gain in 1.5dB steps
// - twist field selects DTMF twist table
// - twist changes only between tones
// - host avoids max twist with 0dB
// - tx mode register field layout
// - address-only command resets all registers
package mcr_pkg;
  localparam logic [7:0] ADDR_RESET = 8'h01;
  localparam logic [7:0] ADDR_GCTRL = 8'he0;
  localparam logic [7:0] ADDR_TXMODE = 8'he1;
  localparam logic [7:0] ADDR_RXMODE = 8'he2;
  localparam int ADDR_BITS = 8;
  localparam int DATA_BITS = 16;
  localparam logic [15:0] REG_RESET = 16'h0000;
  // general control bits
  localparam int GC_LOOP = 11;
  localparam int GC_EQDIS = 10;
  localparam int GC_RELAY = 9;
  localparam int GC_PWR = 8;
  localparam int GC_RST = 7;
  localparam int GC_IRQEN = 6;
  localparam int GC_MASK_MSB = 5;
  // transmit mode fields
  localparam int TM_MODE_LSB = 12;
  localparam int TM_LEVEL_LSB = 9;
  localparam int TM_GUARD_LSB = 7;
  localparam int TM_SCR_LSB = 5;
  localparam int TM_FMT_LSB = 3;
  localparam int TM_TWIST_LSB = 5;
  localparam logic [3:0] TM_MODE_TONES = 4'h1;
  localparam logic [2:0] TM_LEVEL_0DB = 3'h7;
  localparam logic [2:0] TM_TWIST_MAX = 3'h7;
  // timing
  localparam int MCLK_HZ = 100_000_000;
  localparam int MCLK_NS = 10;
  localparam int SETTLE_MS = 20;
  localparam int SETTLE_CYC = SETTLE_MS * (MCLK_HZ / 1000);
  localparam int SCLK_HALF_NS = 40;
  localparam int SCLK_HALF_CYC = SCLK_HALF_NS / MCLK_NS;
  // host command registers
  localparam logic [3:0] HR_ADDR = 4'h0;
  localparam logic [3:0] HR_DATA = 4'h4;
  localparam logic [3:0] HR_CTRL = 4'h8;
  localparam logic [3:0] HR_STAT = 4'hc;
  localparam int HS_BUSY = 0;
  localparam int HS_REFUSED = 1;
  localparam int HS_SETTLING = 2;
  localparam int HS_RESET_SENT = 3;
  localparam int HS_LOOP_MISMATCH = 4;

  typedef enum logic [3:0] {
    MODE_OFF, MODE_TONES, MODE_B202_150, MODE_B202_1200, MODE_V23_75,
    MODE_V23_1200, MODE_B103_CALL, MODE_B103_ANS, MODE_V21_CALL,
    MODE_V21_ANS, MODE_D600_CALL, MODE_D600_ANS, MODE_D1200_CALL,
    MODE_D1200_ANS
  } mcr_mode_type;

  function automatic mcr_mode_type mcr_mode_of(input logic [3:0] c);
    unique case (c)
      4'h1: mcr_mode_of = MODE_TONES;
      4'h2: mcr_mode_of = MODE_B202_150;
      4'h3: mcr_mode_of = MODE_B202_1200;
      4'h4: mcr_mode_of = MODE_V23_75;
      4'h5: mcr_mode_of = MODE_V23_1200;
      4'h6: mcr_mode_of = MODE_B103_CALL;
      4'h7: mcr_mode_of = MODE_B103_ANS;
      4'h8: mcr_mode_of = MODE_V21_CALL;
      4'h9: mcr_mode_of = MODE_V21_ANS;
      4'ha: mcr_mode_of = MODE_D600_CALL;
      4'hb: mcr_mode_of = MODE_D600_ANS;
      4'hc: mcr_mode_of = MODE_D1200_CALL;
      4'hd: mcr_mode_of = MODE_D1200_ANS;
      default: mcr_mode_of = MODE_OFF;
    endcase
  endfunction

  function automatic logic mcr_mode_reserved(input logic [3:0] c);
    mcr_mode_reserved = (c == 4'he) || (c == 4'hf);
  endfunction

  // twist in half-dB units
  function automatic logic [3:0] mcr_twist_half_db(input logic [2:0] c);
    unique case (c)
      3'h0: mcr_twist_half_db = 4'h4;
      3'h1: mcr_twist_half_db = 4'h2;
      3'h2: mcr_twist_half_db = 4'h3;
      3'h3: mcr_twist_half_db = 4'h5;
      3'h4: mcr_twist_half_db = 4'h6;
      3'h5: mcr_twist_half_db = 4'h7;
      3'h6: mcr_twist_half_db = 4'h8;
      3'h7: mcr_twist_half_db = 4'h9;
    endcase
  endfunction
endpackage

// [design/mcr_link_if.sv]
`timescale 1ns/1ns
`default_nettype none
interface mcr_link_if;
  logic csn_n;
  logic sclk;
  logic cdata;
  modport host (output csn_n, output sclk, output cdata);
  modport dev (input csn_n, input sclk, input cdata);
endinterface // mcr_link_if
`default_nettype wire

// [design/mcr_dev.sv]
`timescale 1ns/1ns
`default_nettype none
module mcr_dev (
  input wire logic mclk_i, // system clock
  input wire logic rst_i, // sync reset, active high
  mcr_link_if.dev link, // serial link from host
  input wire logic status_irq_i, // status interrupt flag
  input wire logic [5:0] irq_cond_i, // raw interrupt conditions
  input wire logic tone_active_i, // tone generator mid-tone
  output logic irq_flag_set_o, // masked condition present
  output logic irq_n_o, // interrupt pin level
  output logic irq_oe_o, // interrupt pin enable
  output logic analogue_loopback_enable_o, // loopback on
  output logic eq_disable_o, // equalisers off
  output logic relay_drive_out_n_o, // relay pin, active low
  output logic powerup_o, // high: powered, low: powersave
  output logic ring_detect_enable_o, // always on
  output logic internal_reset_o, // internal circuits held
  output logic status_clear_o, // clear status 13-0
  output logic status_clear_all_o, // pulse: clear 15 and 13-0
  output logic general_reset_o, // pulse: general reset seen
  output logic [5:0] interrupt_mask_o, // mask bits
  output logic [15:0] gctrl_o, // general control register
  output logic [15:0] txmode_o, // transmit mode register
  output mcr_pkg::mcr_mode_type tx_mode_o, // decoded mode
  output logic [4:0] tx_atten_half_db_o, // attenuation, 0.5dB
  output logic [1:0] guard_o, // guard tone field
  output logic [1:0] scrambler_o, // scrambler field
  output logic [1:0] format_o, // data format field
  output logic [2:0] data_bits_o, // data bits/source field
  output logic [3:0] twist_half_db_o, // applied twist, 0.5dB
  output logic [3:0] high_group_gain_half_db_o // high tone gain
);
  import mcr_pkg::*;

  localparam int FRAME_BITS = ADDR_BITS + DATA_BITS;

  logic [1:0] sclk_s_q, csn_s_q, dat_s_q;
  logic sclk_prev_q;
  logic [4:0] cnt_q, cnt_d;
  logic [23:0] sh_q, sh_d;
  logic [15:0] gc_q, gc_d;
  logic [15:0] tm_q, tm_d;
  logic [2:0] twist_q, twist_d;
  logic grst_q, grst_d;
  logic rise;
  logic [23:0] full;

  // pins pass two flops before use
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      sclk_s_q <= 2'h0;
      csn_s_q <= 2'h3;
      dat_s_q <= 2'h0;
      sclk_prev_q <= 1'b0;
    end else begin
      sclk_s_q <= {sclk_s_q[0], link.sclk};
      csn_s_q <= {csn_s_q[0], link.csn_n};
      dat_s_q <= {dat_s_q[0], link.cdata};
      sclk_prev_q <= sclk_s_q[1];
    end
  end

  assign rise = sclk_s_q[1] & ~sclk_prev_q;
  assign full = {sh_q[22:0], dat_s_q[1]};

  always_comb begin
    cnt_d = cnt_q;
    sh_d = sh_q;
    gc_d = gc_q;
    tm_d = tm_q;
    grst_d = 1'b0;
    twist_d = twist_q;
    if (csn_s_q[1]) begin
      cnt_d = 5'h0;
    end else if (rise && cnt_q != 5'(FRAME_BITS)) begin
      sh_d = full;
      cnt_d = cnt_q + 5'h1;
      if (cnt_q == 5'(ADDR_BITS - 1) && full[7:0] == ADDR_RESET) begin
        grst_d = 1'b1;
      end
      if (cnt_q == 5'(FRAME_BITS - 1)) begin
        if (full[23:16] == ADDR_GCTRL) begin
          gc_d = full[15:0];
        end
        if (full[23:16] == ADDR_TXMODE) begin
          tm_d = full[15:0];
        end
      end
    end
    if (gc_d[GC_RST]) begin
      tm_d = REG_RESET;
    end
    if (grst_d) begin
      gc_d = REG_RESET;
      tm_d = REG_RESET;
    end
    // twist latched only between tones
    if (!tone_active_i) begin
      twist_d = tm_q[TM_TWIST_LSB +: 3];
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      cnt_q <= 5'h0;
      sh_q <= 24'h0;
      gc_q <= REG_RESET;
      tm_q <= REG_RESET;
      twist_q <= 3'h0;
      grst_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      sh_q <= sh_d;
      gc_q <= gc_d;
      tm_q <= tm_d;
      twist_q <= twist_d;
      grst_q <= grst_d;
    end
  end

  assign gctrl_o = gc_q;
  assign txmode_o = tm_q;
  assign analogue_loopback_enable_o = gc_q[GC_LOOP];
  assign eq_disable_o = gc_q[GC_EQDIS];
  assign relay_drive_out_n_o = ~gc_q[GC_RELAY];
  assign powerup_o = gc_q[GC_PWR];
  assign ring_detect_enable_o = 1'b1;
  assign internal_reset_o = gc_q[GC_RST] | grst_q;
  assign status_clear_o = gc_q[GC_RST] | grst_q;
  assign status_clear_all_o = grst_q;
  assign general_reset_o = grst_q;
  assign interrupt_mask_o = gc_q[GC_MASK_MSB:0];
  assign irq_flag_set_o = |(irq_cond_i & gc_q[GC_MASK_MSB:0]);
  // open drain: pulls low only when enabled and flagged
  assign irq_n_o = 1'b0;
  assign irq_oe_o = gc_q[GC_IRQEN] & status_irq_i;
  assign tx_mode_o = mcr_mode_of(tm_q[TM_MODE_LSB +: 4]);
  assign tx_atten_half_db_o =
    5'((TM_LEVEL_0DB - tm_q[TM_LEVEL_LSB +: 3]) * 3);
  assign guard_o = tm_q[TM_GUARD_LSB +: 2];
  assign scrambler_o = tm_q[TM_SCR_LSB +: 2];
  assign format_o = tm_q[TM_FMT_LSB +: 2];
  assign data_bits_o = tm_q[2:0];
  assign twist_half_db_o = mcr_twist_half_db(twist_q);
  // twist acts on the high tone group only
  assign high_group_gain_half_db_o = twist_half_db_o;
endmodule // mcr_dev
`default_nettype wire

// [design/mcr_host.sv]
// The implementer's own choice: the plain strobed port.
`timescale 1ns/1ns
`default_nettype none
module mcr_host #(
  parameter int HALF_CYC = mcr_pkg::SCLK_HALF_CYC, // sclk half period
  parameter int SETTLE = mcr_pkg::SETTLE_CYC // powerup settle time
) (
  input wire logic mclk_i, // system clock
  input wire logic rst_i, // sync reset, active high
  input wire logic [3:0] addr_i, // register byte address
  input wire logic [31:0] wdata_i, // write data
  input wire logic wr_i, // write strobe
  input wire logic rd_i, // read strobe
  output logic [31:0] rdata_o, // read data, cycle after rd_i
  mcr_link_if.host link // serial link to device
);
  import mcr_pkg::*;

  typedef enum logic [2:0] {
    ST_IDLE, ST_SEL, ST_LOW, ST_HIGH, ST_END, ST_GAP
  } mcr_hst_type;

  localparam int SW = $clog2(SETTLE + 1);

  mcr_hst_type st_q, st_d;
  logic [7:0] adr_q, adr_d;
  logic [15:0] dat_q, dat_d;
  logic [23:0] sh_q, sh_d;
  logic [4:0] left_q, left_d;
  logic [7:0] div_q, div_d;
  logic csn_q, csn_d, sclk_q, sclk_d, cd_q, cd_d;
  logic refused_q, refused_d, rsent_q, rsent_d;
  logic [SW-1:0] settle_q, settle_d;
  logic loop_q, loop_d;
  logic [3:0] txm_q, txm_d, rxm_q, rxm_d;
  logic [31:0] rdata_d;
  logic start, bad, tick;

  assign start = wr_i && addr_i == HR_CTRL && wdata_i[0];
  assign tick = div_q == 8'(HALF_CYC - 1);
  // tx mode writes checked before sending
  assign bad = adr_q == ADDR_TXMODE &&
    (mcr_mode_reserved(dat_q[TM_MODE_LSB +: 4]) ||
     (dat_q[TM_MODE_LSB +: 4] == TM_MODE_TONES &&
      dat_q[TM_TWIST_LSB +: 3] == TM_TWIST_MAX &&
      dat_q[TM_LEVEL_LSB +: 3] == TM_LEVEL_0DB));

  always_comb begin
    st_d = st_q;
    adr_d = adr_q;
    dat_d = dat_q;
    sh_d = sh_q;
    left_d = left_q;
    div_d = tick ? 8'h0 : div_q + 8'h1;
    csn_d = csn_q;
    sclk_d = sclk_q;
    cd_d = cd_q;
    refused_d = refused_q;
    rsent_d = rsent_q;
    settle_d = settle_q;
    loop_d = loop_q;
    txm_d = txm_q;
    rxm_d = rxm_q;
    if (settle_q != '0) begin
      settle_d = settle_q - SW'(1);
    end
    if (wr_i && addr_i == HR_ADDR && st_q == ST_IDLE) begin
      adr_d = wdata_i[7:0];
    end
    if (wr_i && addr_i == HR_DATA && st_q == ST_IDLE) begin
      dat_d = wdata_i[15:0];
    end
    unique case (st_q)
      ST_IDLE: begin
        if (start && bad) begin
          refused_d = 1'b1;
        end else if (start) begin
          refused_d = 1'b0;
          sh_d = {adr_q, dat_q};
          left_d = adr_q == ADDR_RESET ? 5'(ADDR_BITS) :
            5'(ADDR_BITS + DATA_BITS);
          csn_d = 1'b0;
          div_d = 8'h0;
          st_d = ST_SEL;
          if (adr_q == ADDR_RESET) begin
            rsent_d = 1'b1;
            loop_d = 1'b0;
            txm_d = 4'h0;
            rxm_d = 4'h0;
          end
          if (adr_q == ADDR_GCTRL) begin
            loop_d = dat_q[GC_LOOP];
            if (dat_q[GC_PWR] && dat_q[GC_RST]) begin
              settle_d = SW'(SETTLE);
            end
          end
          if (adr_q == ADDR_TXMODE) begin
            txm_d = dat_q[TM_MODE_LSB +: 4];
          end
          if (adr_q == ADDR_RXMODE) begin
            rxm_d = dat_q[15:12];
          end
        end
      end
      ST_SEL: begin
        if (tick) begin
          st_d = ST_LOW;
          cd_d = sh_q[23];
        end
      end
      ST_LOW: begin
        if (tick) begin
          sclk_d = 1'b1;
          st_d = ST_HIGH;
        end
      end
      ST_HIGH: begin
        if (tick) begin
          sclk_d = 1'b0;
          sh_d = {sh_q[22:0], 1'b0};
          left_d = left_q - 5'h1;
          cd_d = sh_q[22];
          st_d = left_q == 5'h1 ? ST_END : ST_LOW;
        end
      end
      ST_END: begin
        if (tick) begin
          csn_d = 1'b1;
          cd_d = 1'b0;
          st_d = ST_GAP;
        end
      end
      ST_GAP: begin
        if (tick) begin
          st_d = ST_IDLE;
        end
      end
    endcase
    rdata_d = 32'h0;
    if (rd_i) begin
      unique case (addr_i)
        HR_ADDR: rdata_d = {24'h0, adr_q};
        HR_DATA: rdata_d = {16'h0, dat_q};
        HR_STAT: begin
          rdata_d[HS_BUSY] = st_q != ST_IDLE;
          rdata_d[HS_REFUSED] = refused_q;
          rdata_d[HS_SETTLING] = settle_q != '0;
          rdata_d[HS_RESET_SENT] = rsent_q;
          rdata_d[HS_LOOP_MISMATCH] = loop_q && txm_q != rxm_q;
        end
        default: rdata_d = 32'h0;
      endcase
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      st_q <= ST_IDLE;
      adr_q <= 8'h0;
      dat_q <= 16'h0;
      sh_q <= 24'h0;
      left_q <= 5'h0;
      div_q <= 8'h0;
      csn_q <= 1'b1;
      sclk_q <= 1'b0;
      cd_q <= 1'b0;
      refused_q <= 1'b0;
      rsent_q <= 1'b0;
      settle_q <= '0;
      loop_q <= 1'b0;
      txm_q <= 4'h0;
      rxm_q <= 4'h0;
      rdata_o <= 32'h0;
    end else begin
      st_q <= st_d;
      adr_q <= adr_d;
      dat_q <= dat_d;
      sh_q <= sh_d;
      left_q <= left_d;
      div_q <= div_d;
      csn_q <= csn_d;
      sclk_q <= sclk_d;
      cd_q <= cd_d;
      refused_q <= refused_d;
      rsent_q <= rsent_d;
      settle_q <= settle_d;
      loop_q <= loop_d;
      txm_q <= txm_d;
      rxm_q <= rxm_d;
      rdata_o <= rdata_d;
    end
  end

  assign link.csn_n = csn_q;
  assign link.sclk = sclk_q;
  assign link.cdata = cd_q;
endmodule // mcr_host
`default_nettype wire

// [dv/mcr_chk_sva.sv]
`timescale 1ns/1ns
`default_nettype none
module mcr_chk_sva (
  input wire logic mclk_i, // clock
  input wire logic rst_i, // reset
  input wire logic csn_n, // select
  input wire logic sclk, // link clock
  input wire logic status_irq_i, // status flag
  input wire logic [5:0] irq_cond_i, // conditions
  input wire logic irq_flag_set_o, // masked flag
  input wire logic irq_oe_o, // pin enable
  input wire logic analogue_loopback_enable_o, // loop
  input wire logic eq_disable_o, // eq off
  input wire logic relay_drive_out_n_o, // relay
  input wire logic powerup_o, // power
  input wire logic internal_reset_o, // held
  input wire logic general_reset_o, // reset pulse
  input wire logic [15:0] gctrl_o, // control reg
  input wire logic [15:0] txmode_o, // tx mode reg
  input wire logic [4:0] tx_atten_half_db_o, // atten
  input wire logic status_clear_o, // status 13-0 clear
  input wire logic status_clear_all_o // status 15, 13-0 clear
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  property p_loop; analogue_loopback_enable_o == gctrl_o[11]; endproperty
  a_loop: assert property (p_loop) else $error("loopback");
  property p_eq; eq_disable_o == gctrl_o[10]; endproperty
  a_eq: assert property (p_eq) else $error("eq disable");
  property p_rly; relay_drive_out_n_o == !gctrl_o[9]; endproperty
  a_rly: assert property (p_rly) else $error("relay");
  property p_pwr; powerup_o == gctrl_o[8]; endproperty
  a_pwr: assert property (p_pwr) else $error("powerup");
  property p_gr;
    general_reset_o |-> ##[0:1] (gctrl_o == 16'h0 && txmode_o == 16'h0);
  endproperty
  a_gr: assert property (p_gr) else $error("reset cmd");
  property p_rst;
    gctrl_o[7] [*3] |->
      txmode_o == 16'h0 && internal_reset_o && status_clear_o;
  endproperty
  a_rst: assert property (p_rst) else $error("reset bit");
  property p_clr;
    general_reset_o |->
      status_clear_all_o && status_clear_o && internal_reset_o;
  endproperty
  a_clr: assert property (p_clr) else $error("status clear");
  // the reset bit alone leaves status bit 15 alone
  property p_keep15;
    gctrl_o[7] && !general_reset_o |-> !status_clear_all_o;
  endproperty
  a_keep15: assert property (p_keep15) else $error("status 15");
  property p_irq; irq_oe_o == (gctrl_o[6] && status_irq_i); endproperty
  a_irq: assert property (p_irq) else $error("irq pin");
  property p_mask;
    irq_flag_set_o == |(irq_cond_i & gctrl_o[5:0]);
  endproperty
  a_mask: assert property (p_mask) else $error("irq mask");
  property p_att;
    tx_atten_half_db_o == (5'h7 - {2'h0, txmode_o[11:9]}) * 5'h3;
  endproperty
  a_att: assert property (p_att) else $error("tx level");
  property p_idle; csn_n |-> !sclk; endproperty
  a_idle: assert property (p_idle) else $error("idle clock");
  // the general control register only moves while a frame is in flight
  property p_frame; $changed(gctrl_o) |-> $past(csn_n, 3) == 1'b0; endproperty
  a_frame: assert property (p_frame)
    else $error("write outside frame");
endmodule // mcr_chk_sva
`default_nettype wire

// [dv/tb_top.sv]
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import mcr_pkg::*;
  logic mclk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [3:0] addr_i = 4'h0;
  logic [31:0] wdata_i = 32'h0;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic status_irq_i = 1'b0;
  logic [5:0] irq_cond_i = 6'h0;
  logic tone_active_i = 1'b0;
  logic [31:0] rdata_o, rd_v;
  logic irq_flag_set_o, irq_oe_o, analogue_loopback_enable_o, eq_disable_o;
  logic relay_drive_out_n_o, powerup_o, internal_reset_o, general_reset_o;
  logic irq_n_o, ring_detect_enable_o, status_clear_o, status_clear_all_o;
  logic [5:0] interrupt_mask_o;
  logic [15:0] gctrl_o, txmode_o, gctrl2, d;
  mcr_mode_type tx_mode_o;
  logic [4:0] tx_atten_half_db_o;
  logic [1:0] guard_o, scrambler_o, format_o;
  logic [2:0] data_bits_o;
  logic [3:0] twist_half_db_o, high_group_gain_half_db_o;
  int errors = 0;
  int compares = 0;
  int tw[8] = '{4, 2, 3, 5, 6, 7, 8, 9};
  mcr_link_if link();
  mcr_link_if link2();
  always #5 mclk_i = ~mclk_i;
  mcr_host #(.HALF_CYC(4), .SETTLE(600)) mcr_host_i (
    .mclk_i(mclk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .link(link));
  mcr_dev mcr_dev_i (
    .mclk_i(mclk_i), .rst_i(rst_i), .link(link),
    .status_irq_i(status_irq_i), .irq_cond_i(irq_cond_i),
    .tone_active_i(tone_active_i), .irq_flag_set_o(irq_flag_set_o),
    .irq_n_o(irq_n_o), .irq_oe_o(irq_oe_o),
    .analogue_loopback_enable_o(analogue_loopback_enable_o),
    .eq_disable_o(eq_disable_o), .relay_drive_out_n_o(relay_drive_out_n_o),
    .powerup_o(powerup_o), .ring_detect_enable_o(ring_detect_enable_o),
    .internal_reset_o(internal_reset_o), .status_clear_o(status_clear_o),
    .status_clear_all_o(status_clear_all_o),
    .general_reset_o(general_reset_o),
    .interrupt_mask_o(interrupt_mask_o), .gctrl_o(gctrl_o),
    .txmode_o(txmode_o),
    .tx_mode_o(tx_mode_o), .tx_atten_half_db_o(tx_atten_half_db_o),
    .guard_o(guard_o), .scrambler_o(scrambler_o), .format_o(format_o),
    .data_bits_o(data_bits_o), .twist_half_db_o(twist_half_db_o),
    .high_group_gain_half_db_o(high_group_gain_half_db_o));
  // second device on a link driven by the bench to break framing
  mcr_dev mcr_dev_x_i (
    .mclk_i(mclk_i), .rst_i(rst_i), .link(link2), .status_irq_i(1'b0),
    .irq_cond_i(6'h0), .tone_active_i(1'b0), .irq_flag_set_o(),
    .irq_n_o(), .irq_oe_o(), .analogue_loopback_enable_o(),
    .eq_disable_o(), .relay_drive_out_n_o(), .powerup_o(),
    .ring_detect_enable_o(), .internal_reset_o(), .status_clear_o(),
    .status_clear_all_o(), .general_reset_o(), .interrupt_mask_o(),
    .gctrl_o(gctrl2), .txmode_o(), .tx_mode_o(), .tx_atten_half_db_o(),
    .guard_o(), .scrambler_o(), .format_o(), .data_bits_o(),
    .twist_half_db_o(), .high_group_gain_half_db_o());
  mcr_chk_sva mcr_chk_sva_i (
    .mclk_i(mclk_i), .rst_i(rst_i), .csn_n(link.csn_n), .sclk(link.sclk),
    .status_irq_i(status_irq_i), .irq_cond_i(irq_cond_i),
    .irq_flag_set_o(irq_flag_set_o), .irq_oe_o(irq_oe_o),
    .analogue_loopback_enable_o(analogue_loopback_enable_o),
    .eq_disable_o(eq_disable_o), .relay_drive_out_n_o(relay_drive_out_n_o),
    .powerup_o(powerup_o), .internal_reset_o(internal_reset_o),
    .general_reset_o(general_reset_o), .gctrl_o(gctrl_o),
    .txmode_o(txmode_o), .tx_atten_half_db_o(tx_atten_half_db_o),
    .status_clear_o(status_clear_o),
    .status_clear_all_o(status_clear_all_o));
  task automatic complete_run;
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge mclk_i);
    addr_i <= a;
    wdata_i <= v;
    wr_i <= 1'b1;
    @(posedge mclk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge mclk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge mclk_i);
    rd_i <= 1'b0;
    #1;
    rd_v = rdata_o;
  endtask
  task automatic wait_clr(input int b);
    int n;
    n = 0;
    rd(HR_STAT);
    while (rd_v[b] !== 1'b0 && n < 300) begin
      rd(HR_STAT);
      n++;
    end
    chk(32'(rd_v[b]), 32'h0);
  endtask
  task automatic send(input logic [7:0] a, input logic [15:0] v);
    wr(HR_ADDR, 32'(a));
    wr(HR_DATA, 32'(v));
    wr(HR_CTRL, 32'h1);
    wait_clr(HS_BUSY);
    repeat (4) @(posedge mclk_i);
  endtask
  // 80 ns link clock; data line inverted once released
  task automatic bang(input logic [23:0] w, input int n);
    link2.csn_n <= 1'b0;
    for (int i = 0; i < n; i++) begin
      link2.cdata <= w[23 - i];
      repeat (4) @(posedge mclk_i);
      link2.sclk <= 1'b1;
      repeat (4) @(posedge mclk_i);
      link2.sclk <= 1'b0;
    end
    repeat (4) @(posedge mclk_i);
    link2.csn_n <= 1'b1;
    link2.cdata <= ~w[24 - n];
    repeat (10) @(posedge mclk_i);
  endtask
  initial begin
    link2.csn_n = 1'b1;
    link2.sclk = 1'b0;
    link2.cdata = 1'b0;
    repeat (2) @(posedge mclk_i);
    rst_i <= 1'b0;
    @(posedge mclk_i);
    #1;
    chk(32'(relay_drive_out_n_o), 32'h1);
    chk(32'(tx_atten_half_db_o), 32'd21);
    chk(32'(twist_half_db_o), 32'h4);
    chk(32'(ring_detect_enable_o), 32'h1);
    send(ADDR_RESET, 16'h0);
    rd(HR_STAT);
    chk(32'(rd_v[HS_RESET_SENT]), 32'h1);
    send(ADDR_GCTRL, 16'h0fc5);
    chk(32'(gctrl_o), 32'h0fc5);
    chk(32'(analogue_loopback_enable_o), 32'h1);
    chk(32'(eq_disable_o), 32'h1);
    chk(32'(relay_drive_out_n_o), 32'h0);
    chk(32'(powerup_o), 32'h1);
    chk(32'(internal_reset_o), 32'h1);
    chk(32'(status_clear_o), 32'h1);
    chk(32'(interrupt_mask_o), 32'h05);
    rd(HR_STAT);
    chk(32'(rd_v[HS_SETTLING]), 32'h1);
    send(ADDR_RXMODE, 16'h0);
    send(ADDR_TXMODE, 16'hde00);
    chk(32'(txmode_o), 32'h0);
    rd(HR_STAT);
    chk(32'(rd_v[HS_LOOP_MISMATCH]), 32'h1);
    status_irq_i <= 1'b1;
    irq_cond_i <= 6'h04;
    repeat (2) @(posedge mclk_i);
    chk(32'(irq_oe_o), 32'h1);
    chk(32'(irq_n_o), 32'h0);
    chk(32'(irq_flag_set_o), 32'h1);
    irq_cond_i <= 6'h3a;
    repeat (2) @(posedge mclk_i);
    chk(32'(irq_flag_set_o), 32'h0);
    wait_clr(HS_SETTLING);
    send(ADDR_GCTRL, 16'h0105);
    chk(32'(irq_oe_o), 32'h0);
    chk(32'(analogue_loopback_enable_o), 32'h0);
    chk(32'(status_clear_o), 32'h0);
    rd(HR_STAT);
    chk(32'(rd_v[HS_LOOP_MISMATCH]), 32'h0);
    for (int i = 0; i < 14; i++) begin
      d = {i[3:0], i[2:0], 9'(i * 37)};
      send(ADDR_TXMODE, d);
      chk(32'(txmode_o), 32'(d));
      chk(32'(tx_mode_o), 32'(i));
      chk(32'(tx_atten_half_db_o), 32'((7 - i % 8) * 3));
      chk(32'({guard_o, scrambler_o, format_o, data_bits_o}),
        32'(d[8:0]));
    end
    send(ADDR_TXMODE, 16'he000);
    rd(HR_STAT);
    chk(32'(rd_v[HS_REFUSED]), 32'h1);
    send(ADDR_TXMODE, 16'h1fe0);
    rd(HR_STAT);
    chk(32'(rd_v[HS_REFUSED]), 32'h1);
    chk(32'(txmode_o), 32'(d));
    for (int c = 0; c < 8; c++) begin
      send(ADDR_TXMODE, {4'h1, 4'h6, c[2:0], 5'h0});
      chk(32'(twist_half_db_o), 32'(tw[c]));
      chk(32'(high_group_gain_half_db_o), 32'(tw[c]));
    end
    tone_active_i <= 1'b1;
    send(ADDR_TXMODE, 16'h1620);
    chk(32'(twist_half_db_o), 32'h9);
    tone_active_i <= 1'b0;
    repeat (3) @(posedge mclk_i);
    chk(32'(twist_half_db_o), 32'h2);
    send(ADDR_RESET, 16'h0);
    chk(32'(gctrl_o), 32'h0);
    chk(32'(txmode_o), 32'h0);
    chk(32'(powerup_o), 32'h0);
    chk(32'(ring_detect_enable_o), 32'h1);
    bang({ADDR_GCTRL, 16'h0300}, 16);
    chk(32'(gctrl2), 32'h0);
    bang({ADDR_GCTRL, 16'h0300}, 24);
    chk(32'(gctrl2), 32'h0300);
    complete_run();
  end
  initial begin
    #200_000;
    errors++;
    complete_run();
  end
endmodule // tb_top
`default_nettype wire
